// ---- design/pe8_host.sv ----
// Host controller that drives the request and enable pins of an eight-input priority
// encoder and samples its address, group and enable outputs once they have settled.
// Assumes the encoder outputs are asynchronous to i_ref_clk and reach it unregistered.
`timescale 1ns/10ps
module pe8_host (
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	input wire logic [pe8_pkg::REQ_W-1:0] i_req,
	input wire logic i_enable,
	input wire logic [pe8_pkg::ADDR_W-1:0] i_addr_n,
	input wire logic i_group_n,
	input wire logic i_enable_out_n,
	output logic [pe8_pkg::REQ_W-1:0] o_req_n,
	output logic o_cascade_enable_in_n,
	output logic o_valid,
	output logic [pe8_pkg::ADDR_W-1:0] o_addr,
	output logic o_any,
	output logic o_none,
	output logic o_fault,
	output logic o_lower_enable_n
);
	logic [pe8_pkg::REQ_W-1:0] req_n_r;
	logic [pe8_pkg::REQ_W-1:0] req_n_nxt;
	logic en_n_r;
	logic en_n_nxt;
	logic [pe8_pkg::ADDR_W+1:0] pins_raw;
	logic [pe8_pkg::ADDR_W+1:0] pins_s1_r;
	logic [pe8_pkg::ADDR_W+1:0] pins_s1_nxt;
	logic [pe8_pkg::ADDR_W+1:0] pins_s2_r;
	logic [pe8_pkg::ADDR_W+1:0] pins_s2_nxt;
	logic [pe8_pkg::ADDR_W+1:0] last_r;
	logic [pe8_pkg::ADDR_W+1:0] last_nxt;
	pe8_pkg::pe8_state_e state_r;
	pe8_pkg::pe8_state_e state_nxt;
	logic [pe8_pkg::CNT_W-1:0] cnt_r;
	logic [pe8_pkg::CNT_W-1:0] cnt_nxt;
	logic [pe8_pkg::ADDR_W-1:0] addr_r;
	logic [pe8_pkg::ADDR_W-1:0] addr_nxt;
	logic any_r;
	logic any_nxt;
	logic none_r;
	logic none_nxt;
	logic fault_r;
	logic fault_nxt;
	logic lower_en_n_r;
	logic lower_en_n_nxt;
	logic drive_change;
	logic pin_change;
	logic capture;
	logic [pe8_pkg::ADDR_W-1:0] s_addr_n;
	logic s_group_n;
	logic s_eo_n;

	// True when the address pins name no position, as when disabled or idle.
	function automatic logic addr_is_idle(input logic [pe8_pkg::ADDR_W-1:0] addr_n);
		addr_is_idle = (addr_n == pe8_pkg::ADDR_N_IDLE);
	endfunction : addr_is_idle

	// Flags a pin combination that a working encoder can never show.
	function automatic logic pins_illegal(
		input logic en_n,
		input logic [pe8_pkg::ADDR_W-1:0] addr_n,
		input logic group_n,
		input logic eo_n
	);
		logic bad;
		if (en_n) begin
			// A disabled encoder must show every output high, so its address reads seven.
			bad = !addr_is_idle(addr_n) || !group_n || !eo_n;
		end else begin
			// Enabled: exactly one of group and enable output is low, and an idle
			// encoder shows no address.
			bad = (group_n == eo_n) || (group_n && !addr_is_idle(addr_n));
		end
		pins_illegal = bad;
	endfunction : pins_illegal

	// Drive group: user requests are active high; the pins are active low.
	always_comb begin
		req_n_nxt = ~i_req;
		en_n_nxt = ~i_enable;
		drive_change = (req_n_nxt != req_n_r) || (en_n_nxt != en_n_r);
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			req_n_r <= pe8_pkg::REQ_N_IDLE;
			en_n_r <= 1'h1;
		end else begin
			req_n_r <= req_n_nxt;
			en_n_r <= en_n_nxt;
		end
	end

	assign pins_raw = {i_addr_n, i_group_n, i_enable_out_n};

	// Sync group: the encoder pins are asynchronous, so two flip-flops stand
	// before any logic reads them.
	always_comb begin
		pins_s1_nxt = pins_raw;
		pins_s2_nxt = pins_s1_r;
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			pins_s1_r <= pe8_pkg::PINS_IDLE;
			pins_s2_r <= pe8_pkg::PINS_IDLE;
		end else begin
			pins_s1_r <= pins_s1_nxt;
			pins_s2_r <= pins_s2_nxt;
		end
	end

	assign s_addr_n = pins_s2_r[pe8_pkg::ADDR_W+1:2];
	assign s_group_n = pins_s2_r[1];
	assign s_eo_n = pins_s2_r[0];

	// Timing group: a result is taken only after a full quiet window.
	always_comb begin
		last_nxt = pins_s2_r;
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		capture = 1'h0;
		// Each synchronised sample is compared with the one before, so a result
		// qualifies only once successive samples agree.
		pin_change = (pins_s2_r != last_r);
		// Any change on either side restarts the settle window, so transient
		// addresses and the group glitch after enabling are never captured.
		if (drive_change || pin_change) begin
			state_nxt = pe8_pkg::PE8_SETTLE;
			cnt_nxt = pe8_pkg::SETTLE_CYC;
		end else begin
			case (state_r)
				pe8_pkg::PE8_SETTLE: begin
					if (cnt_r == pe8_pkg::CNT_ZERO) begin
						state_nxt = pe8_pkg::PE8_VALID;
						capture = 1'h1;
					end else begin
						cnt_nxt = cnt_r - pe8_pkg::CNT_ONE;
					end
				end
				pe8_pkg::PE8_VALID: begin
					state_nxt = pe8_pkg::PE8_VALID;
				end
				default: begin
					state_nxt = pe8_pkg::PE8_SETTLE;
				end
			endcase
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			last_r <= pe8_pkg::PINS_IDLE;
			state_r <= pe8_pkg::PE8_SETTLE;
			cnt_r <= pe8_pkg::SETTLE_CYC;
		end else begin
			last_r <= last_nxt;
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// Capture group: the settled pins are held until the next capture.
	always_comb begin
		addr_nxt = addr_r;
		any_nxt = any_r;
		none_nxt = none_r;
		fault_nxt = fault_r;
		lower_en_n_nxt = lower_en_n_r;
		if (capture) begin
			// The inverted address is the position of the highest request; a
			// disabled encoder and an idle one both read zero here.
			addr_nxt = ~s_addr_n;
			any_nxt = ~s_group_n;
			none_nxt = ~s_eo_n;
			lower_en_n_nxt = s_eo_n;
			fault_nxt = pins_illegal(en_n_r, s_addr_n, s_group_n, s_eo_n);
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			addr_r <= pe8_pkg::ADDR_ZERO;
			any_r <= 1'h0;
			none_r <= 1'h0;
			fault_r <= 1'h0;
			lower_en_n_r <= 1'h1;
		end else begin
			addr_r <= addr_nxt;
			any_r <= any_nxt;
			none_r <= none_nxt;
			fault_r <= fault_nxt;
			lower_en_n_r <= lower_en_n_nxt;
		end
	end

	assign o_req_n = req_n_r;
	assign o_cascade_enable_in_n = en_n_r;
	assign o_valid = (state_r == pe8_pkg::PE8_VALID);
	assign o_addr = addr_r;
	assign o_any = any_r;
	assign o_none = none_r;
	assign o_fault = fault_r;
	assign o_lower_enable_n = lower_en_n_r;
endmodule : pe8_host

// ---- design/pe8_pkg.sv ----
// Constants for the host-side controller of an eight-input priority encoder.
// Assumes a single 40 MHz clock and a purely combinational encoder on the pins.
package pe8_pkg;
	localparam int REQ_W = 8;
	localparam int ADDR_W = 3;
	localparam int CLK_PERIOD_NS = 25;
	// Least time the encoder pins are given to settle after any change.
	localparam int SETTLE_NS = 200;
	localparam int SETTLE_CYC_INT = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 4;
	localparam logic [CNT_W-1:0] SETTLE_CYC = CNT_W'(SETTLE_CYC_INT);
	localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
	localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
	localparam logic [REQ_W-1:0] REQ_N_IDLE = 8'hff;
	localparam logic [ADDR_W-1:0] ADDR_N_IDLE = 3'h7;
	localparam logic [ADDR_W-1:0] ADDR_ZERO = 3'h0;
	localparam logic [ADDR_W+1:0] PINS_IDLE = 5'h1f;
	typedef enum logic {
		PE8_SETTLE,
		PE8_VALID
	} pe8_state_e;
endpackage : pe8_pkg

// ---- test/pe8_enc_model.sv ----
// Behavioural eight-input priority encoder that stands on the host's pins.
// Assumes active-low pins and answers after a fixed propagation delay.
`timescale 1ns/10ps
module pe8_enc_model (
	input wire logic [7:0] i_req_n,
	input wire logic i_en_n,
	input wire logic i_break,
	output logic [2:0] o_addr_n,
	output logic o_group_n,
	output logic o_enable_out_n
);
	logic [2:0] a;
	always_comb begin
		a = 3'h7;
		for (int k = 0; k < 8; k++)
			if (!i_req_n[k]) a = ~3'(k);
		if (i_en_n) a = 3'h7;
	end
	assign #30 o_addr_n = a;
	// A broken part is mimicked by holding the group output low.
	assign #30 o_group_n = (i_en_n | &i_req_n) & ~i_break;
	assign #30 o_enable_out_n = i_en_n | ~&i_req_n;
endmodule : pe8_enc_model

// ---- test/pe8_host_props.sv ----
// Checker on the host controller ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module pe8_host_props (
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	input wire logic [pe8_pkg::REQ_W-1:0] o_req_n,
	input wire logic o_cascade_enable_in_n,
	input wire logic o_valid,
	input wire logic [pe8_pkg::ADDR_W-1:0] o_addr,
	input wire logic o_any,
	input wire logic o_none,
	input wire logic o_fault,
	input wire logic o_lower_enable_n
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_sys_rst);
	property p_set; $rose(o_valid) |-> $past(o_req_n, 8) == o_req_n; endproperty
	property p_chg; $changed(o_req_n) |-> !o_valid; endproperty
	// A disabled encoder shows every pin high, which reads as position zero.
	property p_dis; $rose(o_valid) && o_cascade_enable_in_n |-> o_addr == 3'h0; endproperty
	property p_low; o_valid |-> o_lower_enable_n == !o_none; endproperty
	property p_cas; o_valid && o_cascade_enable_in_n |-> o_lower_enable_n && !o_none; endproperty
	property p_flt; o_valid && !o_fault && !o_cascade_enable_in_n |-> o_any != o_none; endproperty
	property p_rst; $past(i_sys_rst) |-> !o_valid && o_lower_enable_n && !o_fault; endproperty
	a_set: assert property (p_set) else $error("valid too early");
	a_chg: assert property (p_chg) else $error("valid kept");
	a_dis: assert property (p_dis) else $error("disabled addr");
	a_low: assert property (p_low) else $error("lower enable");
	a_cas: assert property (p_cas) else $error("disabled stage enables next");
	a_flt: assert property (p_flt) else $error("group and none disagree");
	a_rst: assert property (p_rst) else $error("reset values");
	cover property (o_valid && o_fault);
	cover property (o_valid && o_none);
	cover property (o_valid && o_cascade_enable_in_n);
	cover property ($rose(o_valid));
endmodule : pe8_host_props
bind pe8_host pe8_host_props i_pe8_host_props (.*);

// ---- test/tb_top.sv ----
// Self-checking bench for the host controller with an encoder model.
// Assumes a 40 MHz clock and the settling time of the package.
`timescale 1ns/10ps
module tb_top;
	logic clk = 0, rst = 1, en = 0, brk = 0, en_n, grp_n, eo_n, valid, any, none, fault, low_n;
	logic [7:0] req = 0, req_n;
	logic [2:0] addr_n, addr;
	logic [8:0] dir [4] = '{9'h100, 9'h181, 9'h0ff, 9'h101};
	int fails = 0, total_checks = 0;
	pe8_host i_pe8_host (.i_ref_clk(clk), .i_sys_rst(rst), .i_req(req), .i_enable(en),
		.i_addr_n(addr_n), .i_group_n(grp_n), .i_enable_out_n(eo_n), .o_req_n(req_n),
		.o_cascade_enable_in_n(en_n), .o_valid(valid), .o_addr(addr), .o_any(any),
		.o_none(none), .o_fault(fault), .o_lower_enable_n(low_n));
	pe8_enc_model i_pe8_enc_model (.i_req_n(req_n), .i_en_n(en_n), .i_break(brk),
		.o_addr_n(addr_n), .o_group_n(grp_n), .o_enable_out_n(eo_n));
	initial forever #12.5 clk = ~clk;
	task automatic finish_test;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : finish_test
	task automatic cmp_res(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : cmp_res
	task automatic cmp_drv(input logic [8:0] got, input logic [8:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: pins got %h exp %h", $time, got, exp);
		end
	endtask : cmp_drv
	task automatic apply(input logic [7:0] r, input logic e, input logic b);
		int pos;
		int n;
		logic hit;
		logic [7:0] exp;
		pos = -1;
		n = 0;
		for (int k = 0; k < 8; k++) if (r[k]) pos = k;
		hit = e && pos >= 0;
		exp = {1'h1, hit ? 3'(pos) : 3'h0, hit || b, e && pos < 0, b && !hit, !(e && pos < 0)};
		@(negedge clk);
		req = r;
		en = e;
		brk = b;
		// A change seen only on the pins drops valid three edges late.
		repeat (5) @(negedge clk);
		while (valid !== 1'h1 && n < 40) begin
			@(negedge clk);
			n++;
		end
		cmp_drv({req_n, en_n}, {~r, ~e});
		cmp_res({valid, addr, any, none, fault, low_n}, exp);
	endtask : apply
	initial begin
		void'($urandom(25));
		repeat (8) @(posedge clk);
		@(negedge clk) rst = 0;
		foreach (dir[i]) apply(dir[i][7:0], dir[i][8], 1'h0);
		$display("directed test done");
		repeat (40) apply(8'($urandom), $urandom % 4 != 0, 1'h0);
		$display("random test done");
		apply(8'h00, 1'h0, 1'h1);
		apply(8'h00, 1'h1, 1'h1);
		apply(8'h24, 1'h1, 1'h1);
		$display("fault test done");
		@(negedge clk) rst = 1;
		repeat (2) @(negedge clk);
		cmp_res({valid, addr, any, none, fault, low_n}, 8'h01);
		cmp_drv({req_n, en_n}, 9'h1ff);
		rst = 0;
		apply(req, en, 1'h0);
		$display("reset test done");
		finish_test;
	end
	initial begin
		#200000;
		fails++;
		finish_test;
	end
endmodule : tb_top
